// ### verilog/apr_pkg.sv
// Purpose: shared constants for the partner ability and expansion registers
// Assumes: 16-bit management registers reached by register index
// Notes: bit positions follow the register layout
package apr_pkg;
    timeunit 1ns;
    timeprecision 100ps;
    // ----------------------------------------------------------------
    // register indices and widths
    // ----------------------------------------------------------------
    localparam int APR_ADDR_W = 5;
    localparam int APR_DATA_W = 16;
    localparam logic [4:0] APR_IDX_PARTNER = 5'h05;
    localparam logic [4:0] APR_IDX_EXPANSION = 5'h06;
    // ----------------------------------------------------------------
    // partner ability word fields
    // ----------------------------------------------------------------
    localparam int APR_BIT_MORE = 15;
    localparam int APR_BIT_ACK = 14;
    localparam int APR_BIT_FAULT = 13;
    localparam int APR_BIT_MSG = 13;
    localparam int APR_BIT_COMPLY = 12;
    localparam int APR_BIT_TOGGLE = 11;
    localparam int APR_TECH_HI = 12;
    localparam int APR_TECH_LO = 5;
    localparam int APR_SEL_HI = 4;
    localparam int APR_SEL_LO = 0;
    localparam int APR_CODE_HI = 10;
    localparam int APR_CODE_LO = 0;
    // ----------------------------------------------------------------
    // expansion status fields
    // ----------------------------------------------------------------
    localparam int APR_BIT_PDF = 4;
    localparam int APR_BIT_LPNP = 3;
    localparam int APR_BIT_NPABLE = 2;
    localparam int APR_BIT_PGREC = 1;
    localparam int APR_BIT_LPAN = 0;
    // ----------------------------------------------------------------
    // reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] APR_WORD_RST = 16'h0000;
    localparam logic [15:0] APR_RD_RST = 16'h0000;
    // page form selector
    typedef enum logic [0:0] {
        APR_FORM_BASE = 1'b0,
        APR_FORM_NEXT = 1'b1
    } apr_form_t;
endpackage

// ### verilog/apr_partner_regs.sv
// Purpose: partner ability word and negotiation expansion status registers
// Assumes: negotiation engine on core_clk_in drives the received-word
//          strobes; management reads arrive as a one-cycle read strobe
// Notes: partner word contents are only meaningful once complete is set
//
// How it works
// - base form bit 15 shows partner next-page request
// - base form bit 14 shows partner acknowledge
// - base form bit 13 shows partner fault
// - base form bits 12..5 hold technology field
// - base form bits 4..0 hold selector field
// - next form bit 15 shows more pages follow
// - next form bit 14 shows partner acknowledge
// - next form bit 13 marks message page
// - next form bit 12 shows partner can comply
// - next form bit 11 holds partner toggle
// - next form bits 10..0 hold code field
// - parallel detect fault latches, read clears
// - expansion bit 3 shows partner next-page support
// - expansion bit 2 always reads one
// - expansion bit 1 latches on each page
// - expansion bit 0 shows partner can negotiate
// - expansion upper bits reserved, writes ignored
// - complete flag validates word, restart clears it
module apr_partner_regs (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic nrst_in,
    // management access
    input wire logic mgmt_rd_in,
    input wire logic mgmt_wr_in,
    input wire logic [apr_pkg::APR_ADDR_W-1:0] mgmt_addr_in,
    input wire logic [apr_pkg::APR_DATA_W-1:0] mgmt_wdata_in,
    // negotiation engine
    input wire logic page_strobe_in,
    input wire logic page_is_next_in,
    input wire logic [apr_pkg::APR_DATA_W-1:0] page_word_in,
    input wire logic parallel_detect_fault_in,
    input wire logic partner_can_negotiate_in,
    input wire logic negotiation_done_in,
    input wire logic negotiation_restart_in,
    // read answer and status
    output logic [apr_pkg::APR_DATA_W-1:0] mgmt_rdata_out,
    output logic mgmt_rvalid_out,
    output logic page_form_out,
    output logic negotiation_complete_flag_out
);
    timeunit 1ns;
    timeprecision 100ps;
    import apr_pkg::*;

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    // latest page, held as the fields of both forms
    logic partner_more_pages_reg;
    logic partner_acknowledge_reg;
    logic partner_fault_flag_reg;
    logic [APR_TECH_HI-APR_TECH_LO:0] partner_technology_field_reg;
    logic [APR_SEL_HI-APR_SEL_LO:0] partner_selector_field_reg;
    logic partner_message_page_flag_reg;
    logic partner_comply_flag_reg;
    logic partner_toggle_bit_reg;
    logic [APR_CODE_HI-APR_CODE_LO:0] message_code_field_reg;
    logic [15:0] partner_word;
    apr_form_t form_reg;
    logic supports_extra_reg;
    logic parallel_detect_fault_reg;
    logic page_received_flag_reg;
    logic partner_can_negotiate_reg;
    logic complete_reg;
    logic [15:0] rdata_reg;
    logic rvalid_reg;
    logic [15:0] expansion_word;
    logic exp_read;

    // decodes a register index against a target
    function automatic logic hit(input logic [4:0] a, input logic [4:0] t);
        hit = (a == t);
    endfunction

    // packs the base-page view: request, acknowledge, fault and the
    // technology and selector fields at their fixed positions
    function automatic logic [15:0] pack_base(
        input logic more,
        input logic ack,
        input logic fault,
        input logic [APR_TECH_HI-APR_TECH_LO:0] tech,
        input logic [APR_SEL_HI-APR_SEL_LO:0] sel
    );
        pack_base = 16'h0000;
        pack_base[APR_BIT_MORE] = more;
        pack_base[APR_BIT_ACK] = ack;
        pack_base[APR_BIT_FAULT] = fault;
        pack_base[APR_TECH_HI:APR_TECH_LO] = tech;
        pack_base[APR_SEL_HI:APR_SEL_LO] = sel;
    endfunction

    // packs the next-page view: flags, toggle and the code field; bit 13
    // and bit 12 here mean something other than in the base view
    function automatic logic [15:0] pack_next(
        input logic more,
        input logic ack,
        input logic msg,
        input logic comply,
        input logic toggle,
        input logic [APR_CODE_HI-APR_CODE_LO:0] code
    );
        pack_next = 16'h0000;
        pack_next[APR_BIT_MORE] = more;
        pack_next[APR_BIT_ACK] = ack;
        pack_next[APR_BIT_MSG] = msg;
        pack_next[APR_BIT_COMPLY] = comply;
        pack_next[APR_BIT_TOGGLE] = toggle;
        pack_next[APR_CODE_HI:APR_CODE_LO] = code;
    endfunction

    // write strobe and data stay undecoded: every field here is
    // read-only, so a write has no effect at all
    assign exp_read = mgmt_rd_in && hit(mgmt_addr_in, APR_IDX_EXPANSION);

    // ----------------------------------------------------------------
    // partner ability word capture
    // ----------------------------------------------------------------
    // fields are kept apart so each form's bits come from a page of
    // that form; bits 15 and 14 mean the same in both, so any page loads
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            partner_more_pages_reg <= APR_WORD_RST[APR_BIT_MORE];
        end else if (page_strobe_in) begin
            partner_more_pages_reg <= page_word_in[APR_BIT_MORE];
        end
    end

    // acknowledge: bursts seen consistently, or last word taken
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            partner_acknowledge_reg <= APR_WORD_RST[APR_BIT_ACK];
        end else if (page_strobe_in) begin
            partner_acknowledge_reg <= page_word_in[APR_BIT_ACK];
        end
    end

    // base-page fields load from base pages only, so the base view
    // stays whole while next pages come and go
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            partner_fault_flag_reg <= APR_WORD_RST[APR_BIT_FAULT];
        end else if (page_strobe_in && !page_is_next_in) begin
            partner_fault_flag_reg <= page_word_in[APR_BIT_FAULT];
        end
    end

    // technology field, bit meanings as in the local advertisement
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            partner_technology_field_reg <=
                APR_WORD_RST[APR_TECH_HI:APR_TECH_LO];
        end else if (page_strobe_in && !page_is_next_in) begin
            partner_technology_field_reg <=
                page_word_in[APR_TECH_HI:APR_TECH_LO];
        end
    end

    // selector is passed as received; no check against the usual code
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            partner_selector_field_reg <=
                APR_WORD_RST[APR_SEL_HI:APR_SEL_LO];
        end else if (page_strobe_in && !page_is_next_in) begin
            partner_selector_field_reg <=
                page_word_in[APR_SEL_HI:APR_SEL_LO];
        end
    end

    // ----------------------------------------------------------------
    // next-page fields
    // ----------------------------------------------------------------
    // next-page fields load from next pages only, so a base page that
    // arrives later leaves them alone until the form flips back
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            partner_message_page_flag_reg <= APR_WORD_RST[APR_BIT_MSG];
        end else if (page_strobe_in && page_is_next_in) begin
            partner_message_page_flag_reg <= page_word_in[APR_BIT_MSG];
        end
    end

    // partner's ability to comply with the message
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            partner_comply_flag_reg <= APR_WORD_RST[APR_BIT_COMPLY];
        end else if (page_strobe_in && page_is_next_in) begin
            partner_comply_flag_reg <= page_word_in[APR_BIT_COMPLY];
        end
    end

    // toggle is reported as received; sync checking is the engine's job
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            partner_toggle_bit_reg <= APR_WORD_RST[APR_BIT_TOGGLE];
        end else if (page_strobe_in && page_is_next_in) begin
            partner_toggle_bit_reg <= page_word_in[APR_BIT_TOGGLE];
        end
    end

    // message or unformatted code, all eleven bits kept
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            message_code_field_reg <=
                APR_WORD_RST[APR_CODE_HI:APR_CODE_LO];
        end else if (page_strobe_in && page_is_next_in) begin
            message_code_field_reg <=
                page_word_in[APR_CODE_HI:APR_CODE_LO];
        end
    end

    // form of the word follows the type of the latest page
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            form_reg <= APR_FORM_BASE;
        end else if (page_strobe_in) begin
            form_reg <= page_is_next_in ? APR_FORM_NEXT : APR_FORM_BASE;
        end
    end

    // partner next-page ability comes from the base page's bit 15
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            supports_extra_reg <= 1'b0;
        end else if (page_strobe_in && !page_is_next_in) begin
            supports_extra_reg <= page_word_in[APR_BIT_MORE];
        end
    end

    // ----------------------------------------------------------------
    // latched expansion bits 4 and 1, registered level bit 0
    // ----------------------------------------------------------------
    // set wins over the read clear so no event is lost
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            parallel_detect_fault_reg <= 1'b0;
        end else if (parallel_detect_fault_in) begin
            parallel_detect_fault_reg <= 1'b1;
        end else if (exp_read) begin
            parallel_detect_fault_reg <= 1'b0;
        end
    end

    // page received flag: latch on any page, read clears
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            page_received_flag_reg <= 1'b0;
        end else if (page_strobe_in) begin
            page_received_flag_reg <= 1'b1;
        end else if (exp_read) begin
            page_received_flag_reg <= 1'b0;
        end
    end

    // partner negotiation ability is a level from the engine
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            partner_can_negotiate_reg <= 1'b0;
        end else begin
            partner_can_negotiate_reg <= partner_can_negotiate_in;
        end
    end

    // ----------------------------------------------------------------
    // completion flag
    // ----------------------------------------------------------------
    // restart dominates so a stale done cannot validate old contents
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            complete_reg <= 1'b0;
        end else if (negotiation_restart_in) begin
            complete_reg <= 1'b0;
        end else if (negotiation_done_in) begin
            complete_reg <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // read path
    // ----------------------------------------------------------------
    // reserved upper bits read zero; writes are simply not decoded
    always_comb begin
        expansion_word = 16'h0000;
        expansion_word[APR_BIT_PDF] = parallel_detect_fault_reg;
        expansion_word[APR_BIT_LPNP] = supports_extra_reg;
        expansion_word[APR_BIT_NPABLE] = 1'b1;
        expansion_word[APR_BIT_PGREC] = page_received_flag_reg;
        expansion_word[APR_BIT_LPAN] = partner_can_negotiate_reg;
    end

    // the form chooses which field set the partner word shows; both
    // views are built from the same latest request and acknowledge
    always_comb begin
        partner_word = APR_WORD_RST;
        case (form_reg)
            APR_FORM_BASE: begin
                partner_word = pack_base(partner_more_pages_reg,
                    partner_acknowledge_reg, partner_fault_flag_reg,
                    partner_technology_field_reg,
                    partner_selector_field_reg);
            end
            APR_FORM_NEXT: begin
                partner_word = pack_next(partner_more_pages_reg,
                    partner_acknowledge_reg,
                    partner_message_page_flag_reg,
                    partner_comply_flag_reg, partner_toggle_bit_reg,
                    message_code_field_reg);
            end
            default: begin
                partner_word = APR_WORD_RST;
            end
        endcase
    end

    // read data registered one cycle after the strobe
    always_ff @(posedge core_clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_reg <= APR_RD_RST;
            rvalid_reg <= 1'b0;
        end else begin
            rvalid_reg <= mgmt_rd_in;
            if (mgmt_rd_in) begin
                if (hit(mgmt_addr_in, APR_IDX_PARTNER)) begin
                    rdata_reg <= partner_word;
                end else if (exp_read) begin
                    rdata_reg <= expansion_word;
                end else begin
                    rdata_reg <= 16'h0000;
                end
            end
        end
    end

    assign mgmt_rdata_out = rdata_reg;
    assign mgmt_rvalid_out = rvalid_reg;
    assign page_form_out = form_reg;
    assign negotiation_complete_flag_out = complete_reg;
endmodule

// ### verification/apr_mgmt_model.sv
// Purpose: management station model issuing single register accesses
// Assumes: the block answers one cycle after the strobe edge
// Notes: a released index shows its inverse so stale values cannot pass
module apr_mgmt_model (
    // answer from the block
    input wire logic clk_in,
    input wire logic [15:0] rdata_in,
    input wire logic rvalid_in,
    // access request
    output logic rd_out = 1'b0,
    output logic wr_out = 1'b0,
    output logic [4:0] addr_out = 5'h1F,
    output logic [15:0] wdata_out = 16'h0000
);
    timeunit 1ns;
    timeprecision 100ps;
    // strobe held until the taking edge, answer taken 1 ns after that same edge
    task automatic access(input logic w, input logic [4:0] a,
        input logic [15:0] d, output logic [15:0] q);
        @(posedge clk_in);
        #1 rd_out = !w;
        wr_out = w;
        addr_out = a;
        wdata_out = d;
        @(posedge clk_in);
        #1 rd_out = 1'b0;
        wr_out = 1'b0;
        addr_out = ~a;
        wdata_out = ~d;
        q = rvalid_in ? rdata_in : 16'hFFFF;
    endtask
endmodule

// ### verification/apr_partner_regs_checker.sv
// Purpose: port-level checks of the partner and expansion registers
// Assumes: read answer lands one cycle after the read edge
// Notes: latched bits are judged two reads apart, set beats clear
module apr_partner_regs_checker (
    input wire logic core_clk_in,
    input wire logic nrst_in,
    input wire logic mgmt_rd_in,
    input wire logic [4:0] mgmt_addr_in,
    input wire logic page_strobe_in,
    input wire logic page_is_next_in,
    input wire logic [15:0] page_word_in,
    input wire logic parallel_detect_fault_in,
    input wire logic partner_can_negotiate_in,
    input wire logic negotiation_restart_in,
    input wire logic [15:0] mgmt_rdata_out,
    input wire logic mgmt_rvalid_out,
    input wire logic page_form_out,
    input wire logic negotiation_complete_flag_out
);
    timeunit 1ns;
    timeprecision 100ps;
    import apr_pkg::*;
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (!nrst_in);
    logic exp_rd;
    logic part_rd;
    // decoded read requests
    assign exp_rd = mgmt_rd_in && mgmt_addr_in == APR_IDX_EXPANSION;
    assign part_rd = mgmt_rd_in && mgmt_addr_in == APR_IDX_PARTNER;
    sequence s_rd_twice;
        (exp_rd && !page_strobe_in) ##1 !page_strobe_in ##1 exp_rd;
    endsequence
    sequence s_pdf_twice;
        (exp_rd && !parallel_detect_fault_in) ##1
            !parallel_detect_fault_in ##1 exp_rd;
    endsequence
    property p_rvalid; mgmt_rd_in |=> mgmt_rvalid_out; endproperty
    property p_fixed;
        exp_rd |=> mgmt_rdata_out[2] && mgmt_rdata_out[15:5] == 11'h000;
    endproperty
    property p_pgrec;
        page_strobe_in ##1 !exp_rd [*3] ##1 exp_rd |=> mgmt_rdata_out[1];
    endproperty
    property p_rdclr; s_rd_twice |=> !mgmt_rdata_out[1]; endproperty
    property p_pdf;
        parallel_detect_fault_in ##1 !exp_rd ##1 exp_rd
            |=> mgmt_rdata_out[4];
    endproperty
    property p_pdfclr; s_pdf_twice |=> !mgmt_rdata_out[4]; endproperty
    property p_word;
        page_strobe_in ##1 !page_strobe_in ##1 (part_rd && !page_strobe_in)
            |=> mgmt_rdata_out == $past(page_word_in, 3);
    endproperty
    property p_form;
        page_strobe_in |=> page_form_out == $past(page_is_next_in);
    endproperty
    property p_restart;
        negotiation_restart_in |=> !negotiation_complete_flag_out;
    endproperty
    property p_lpan;
        exp_rd |=> mgmt_rdata_out[0] == $past(partner_can_negotiate_in, 2);
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("no read answer");
    a_fixed: assert property (p_fixed) else $error("bad fixed bits");
    a_pgrec: assert property (p_pgrec) else $error("page not latched");
    a_rdclr: assert property (p_rdclr) else $error("page not cleared");
    a_pdf: assert property (p_pdf) else $error("fault not latched");
    a_pdfclr: assert property (p_pdfclr) else $error("fault stuck");
    a_word: assert property (p_word) else $error("bad word");
    a_form: assert property (p_form) else $error("bad form");
    a_restart: assert property (p_restart) else $error("flag kept");
    a_lpan: assert property (p_lpan) else $error("bad bit 0");
endmodule
bind apr_partner_regs apr_partner_regs_checker apr_partner_regs_checker_i (.*);

// ### verification/tb.sv
// Purpose: self-checking bench for the partner and expansion registers
// Assumes: inputs change 1 ns after the rising edge
// Notes: rows send one page each, hand tests cover latches and reset
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    import apr_pkg::*;
    typedef struct {logic nx; logic [15:0] w;} apr_row_t;
    apr_row_t rows [5] = '{'{1'b0, 16'h2001}, '{1'b0, 16'hC1E1},
        '{1'b1, 16'hA7FF}, '{1'b1, 16'h5800}, '{1'b1, 16'h0000}};
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic strobe = 1'b0;
    logic is_next = 1'b0;
    logic pdf = 1'b0;
    logic lpan = 1'b0;
    logic done = 1'b0;
    logic rst = 1'b0;
    logic np_able = 1'b0;
    logic [15:0] word = 16'h0000;
    logic [15:0] q, rdata, wd;
    logic rd, wr, rv, form, cmpl;
    logic [4:0] addr;
    int error_cnt = 0;
    int checked = 0;
    always #10 clk = ~clk;
    apr_partner_regs apr_partner_regs_i (.core_clk_in(clk), .nrst_in(nrst),
        .mgmt_rd_in(rd), .mgmt_wr_in(wr), .mgmt_addr_in(addr),
        .mgmt_wdata_in(wd), .page_strobe_in(strobe),
        .page_is_next_in(is_next), .page_word_in(word),
        .parallel_detect_fault_in(pdf), .partner_can_negotiate_in(lpan),
        .negotiation_done_in(done), .negotiation_restart_in(rst),
        .mgmt_rdata_out(rdata), .mgmt_rvalid_out(rv),
        .page_form_out(form), .negotiation_complete_flag_out(cmpl));
    apr_mgmt_model apr_mgmt_model_i (.clk_in(clk), .rdata_in(rdata),
        .rvalid_in(rv), .rd_out(rd), .wr_out(wr), .addr_out(addr),
        .wdata_out(wd));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic rdw(input logic [4:0] a, output logic [15:0] d);
        apr_mgmt_model_i.access(1'b0, a, 16'h0000, d);
    endtask
    task automatic end_sim();
        $display("checked=%0d error_cnt=%0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // a hang well past the expected run of under a hundred cycles ends the run
    initial begin
        #200000 error_cnt++;
        end_sim();
    end
    initial begin
        repeat (6) @(posedge clk);
        #1 nrst = 1'b1;
        chk(rdata | {14'h0, form, cmpl}, 16'h0000);
        lpan = 1'b1;
        foreach (rows[i]) begin
            @(posedge clk);
            #1 strobe = 1'b1;
            is_next = rows[i].nx;
            word = rows[i].w;
            @(posedge clk);
            #1 strobe = 1'b0;
            word = ~word;
            if (!rows[i].nx)
                np_able = rows[i].w[15];
            rdw(APR_IDX_PARTNER, q);
            chk(q, rows[i].w);
            chk({15'h0, form}, {15'h0, rows[i].nx});
            rdw(APR_IDX_EXPANSION, q);
            chk(q, {12'h0, np_able, 3'b111});
            rdw(APR_IDX_EXPANSION, q);
            chk(q, {12'h0, np_able, 3'b101});
        end
        $display("page rows done");
        @(posedge clk);
        #1 pdf = 1'b1;
        lpan = 1'b0;
        @(posedge clk);
        #1 pdf = 1'b0;
        rdw(APR_IDX_EXPANSION, q);
        chk(q, {11'h0, 1'b1, np_able, 3'b100});
        rdw(APR_IDX_EXPANSION, q);
        chk(q, {12'h0, np_able, 3'b100});
        apr_mgmt_model_i.access(1'b1, APR_IDX_EXPANSION, 16'hFFFF, q);
        rdw(APR_IDX_EXPANSION, q);
        chk(q, {12'h0, np_able, 3'b100});
        rdw(5'h1F, q);
        chk(q, 16'h0000);
        // page and fault land on the edge that takes an expansion read
        fork
            rdw(APR_IDX_EXPANSION, q);
            begin
                @(posedge clk);
                #1 strobe = 1'b1;
                pdf = 1'b1;
                is_next = 1'b1;
                word = 16'h0123;
                @(posedge clk);
                #1 strobe = 1'b0;
                pdf = 1'b0;
                word = ~word;
            end
        join
        chk(q, {12'h0, np_able, 3'b100});
        rdw(APR_IDX_EXPANSION, q);
        chk(q, {11'h0, 1'b1, np_able, 3'b110});
        rdw(APR_IDX_PARTNER, q);
        chk(q, 16'h0123);
        done = 1'b1;
        @(posedge clk);
        #1 chk({15'h0, cmpl}, 16'h0001);
        rst = 1'b1;
        @(posedge clk);
        #1 chk({15'h0, cmpl}, 16'h0000);
        $display("latch and flag tests done");
        @(posedge clk);
        #1 nrst = 1'b0;
        done = 1'b0;
        rst = 1'b0;
        @(posedge clk);
        #1 nrst = 1'b1;
        rdw(APR_IDX_PARTNER, q);
        chk(q | {14'h0, form, cmpl}, APR_WORD_RST);
        $display("mid-run reset test done");
        end_sim();
    end
endmodule
